// File: rtl/jcid_pkg.sv
/*
 * Constants, state encodings and carrier structs for the JTAG configuration
 * instruction decoder. Assumes one 100 MHz system clock and an AXI4-Lite
 * register bus; the TAP pins arrive asynchronously from an external controller.
 */
package jcid_pkg;

	localparam int IR_W = 8;
	typedef logic [IR_W-1:0] jcid_op_t;

	// Instruction opcodes
	localparam jcid_op_t OP_EXTEST          = 8'h00;
	localparam jcid_op_t OP_SET_COL_ADDR    = 8'h01;
	localparam jcid_op_t OP_SHIFT_COL_DATA  = 8'h02;
	localparam jcid_op_t OP_WIPE_ALL        = 8'h03;
	localparam jcid_op_t OP_WRITE_COL       = 8'h07;
	localparam jcid_op_t OP_LOCK_READOUT    = 8'h09;
	localparam jcid_op_t OP_READ_COL        = 8'h0A;
	localparam jcid_op_t OP_DISCHARGE       = 8'h14;
	localparam jcid_op_t OP_PROG_ENABLE     = 8'h15;
	localparam jcid_op_t OP_IDCODE          = 8'h16;
	localparam jcid_op_t OP_USERCODE        = 8'h17;
	localparam jcid_op_t OP_HIGHZ           = 8'h18;
	localparam jcid_op_t OP_STORE_USER_SIG  = 8'h1A;
	localparam jcid_op_t OP_SAMPLE          = 8'h1C;
	localparam jcid_op_t OP_PROG_DISABLE    = 8'h1E;
	localparam jcid_op_t OP_CLAMP           = 8'h20;
	localparam jcid_op_t OP_CLR_CFG_VALID   = 8'h24;
	localparam jcid_op_t OP_WRITE_COL_STEP  = 8'h27;
	localparam jcid_op_t OP_READ_COL_STEP   = 8'h2A;
	localparam jcid_op_t OP_INTEST          = 8'h2C;
	localparam jcid_op_t OP_SET_CFG_VALID   = 8'h2F;
	localparam jcid_op_t OP_IDLE_CLAMP_ALIAS = 8'h30;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_COL_ADDR = 8'h08;
	localparam logic [7:0] REG_USER_SIG = 8'h0C;
	localparam logic [7:0] REG_IDCODE   = 8'h10;

	// Control field positions and reset values
	localparam int   CTRL_TAP_RESET_BIT = 0;
	localparam int   CTRL_LINK_EN_BIT   = 1;
	localparam logic CTRL_TAP_RESET_RST = 1'b0;
	localparam logic CTRL_LINK_EN_RST   = 1'b1;

	// Status field positions
	localparam int ST_PROG_MODE_BIT = 0;
	localparam int ST_LOCK_BIT      = 1;
	localparam int ST_CFG_VALID_BIT = 2;
	localparam int ST_VPP_BIT       = 3;
	localparam int ST_PENDING_BIT   = 4;
	localparam int ST_IR_LSB        = 8;
	localparam int ST_TAP_LSB       = 16;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [15:0] {
		TAP_RESET      = 16'h0001,
		TAP_IDLE       = 16'h0002,
		TAP_SEL_DR     = 16'h0004,
		TAP_CAPTURE_DR = 16'h0008,
		TAP_SHIFT_DR   = 16'h0010,
		TAP_EXIT1_DR   = 16'h0020,
		TAP_PAUSE_DR   = 16'h0040,
		TAP_EXIT2_DR   = 16'h0080,
		TAP_UPDATE_DR  = 16'h0100,
		TAP_SEL_IR     = 16'h0200,
		TAP_CAPTURE_IR = 16'h0400,
		TAP_SHIFT_IR   = 16'h0800,
		TAP_EXIT1_IR   = 16'h1000,
		TAP_PAUSE_IR   = 16'h2000,
		TAP_EXIT2_IR   = 16'h4000,
		TAP_UPDATE_IR  = 16'h8000
	} jcid_tap_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jcid_tap_in_s;

	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} jcid_tap_out_s;

	typedef struct packed {
		logic outputs_highz;
		logic drive_from_bsr;
		logic intest_mode;
		logic config_valid;
		logic program_supply_on;
	} jcid_pin_ctl_s;

endpackage

// File: rtl/jcid_top.sv
/*
 * JTAG instruction decoder and configuration sequencer with an AXI4-Lite
 * status/control slave. Assumes TCK, TMS and TDI are asynchronous pins,
 * TCK well below a quarter of aclk, and the non-volatile array modelled in
 * flip-flops. The TDO pad merges tdo and tdo_oe outside this module.
 */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps

module jcid_top #(
	parameter int          COL_ADDR_W = 10,
	parameter int          COL_DATA_W = 43,
	parameter int          NUM_COLS   = 16,
	parameter int          BSR_W      = 16,
	parameter logic [31:0] ID_CODE    = 32'h0A5C_3001 // Arbitrary value
) (
	input  wire logic                    aclk,          // System clock
	input  wire logic                    aresetn,       // Sync reset, low
	input  wire jcid_pkg::jcid_tap_in_s  tap_in,        // TCK, TMS, TDI pins
	output jcid_pkg::jcid_tap_out_s      tap_out,       // TDO and enable
	input  wire logic [BSR_W-1:0]        pin_state,     // Present pin levels
	output logic [BSR_W-1:0]             bsr_drive,     // Boundary update latch
	output jcid_pkg::jcid_pin_ctl_s      pin_ctl,       // Pin/core mode controls
	input  wire logic [7:0]              s_axi_awaddr,  // Write address
	input  wire logic                    s_axi_awvalid, // Write address valid
	output logic                         s_axi_awready, // Write address ready
	input  wire logic [31:0]             s_axi_wdata,   // Write data
	input  wire logic [3:0]              s_axi_wstrb,   // Write strobes
	input  wire logic                    s_axi_wvalid,  // Write data valid
	output logic                         s_axi_wready,  // Write data ready
	output logic [1:0]                   s_axi_bresp,   // Write response
	output logic                         s_axi_bvalid,  // Write response valid
	input  wire logic                    s_axi_bready,  // Write response ready
	input  wire logic [7:0]              s_axi_araddr,  // Read address
	input  wire logic                    s_axi_arvalid, // Read address valid
	output logic                         s_axi_arready, // Read address ready
	output logic [31:0]                  s_axi_rdata,   // Read data
	output logic [1:0]                   s_axi_rresp,   // Read response
	output logic                         s_axi_rvalid,  // Read data valid
	input  wire logic                    s_axi_rready   // Read data ready
);

	typedef struct packed {
		logic                                 tck1, tck2, tck3;
		logic                                 tms1, tms2, tdi1, tdi2;
		jcid_pkg::jcid_tap_e                  tap;
		jcid_pkg::jcid_op_t                   ir;
		jcid_pkg::jcid_op_t                   ir_sh;
		logic                                 byp;
		logic [31:0]                          id_sh;
		logic [COL_ADDR_W-1:0]                col_addr;
		logic [COL_DATA_W-1:0]                col_data;
		logic [31:0]                          sig_sh;
		logic [31:0]                          sig_nv;
		logic [BSR_W-1:0]                     bsr_sh;
		logic [BSR_W-1:0]                     bsr_upd;
		logic [NUM_COLS-1:0][COL_DATA_W-1:0]  nv;
		logic                                 prog_mode, lock, cfg_valid, vpp, pending;
		jcid_pkg::jcid_pin_ctl_s              ctl;
		jcid_pkg::jcid_tap_out_s              to;
		logic                                 tap_reset, link_en;
		logic                                 aw_held, w_held;
		logic [7:0]                           aw_addr;
		logic [31:0]                          w_data;
		logic [3:0]                           w_strb;
		logic                                 bvalid;
		logic [1:0]                           bresp;
		logic                                 rvalid;
		logic [31:0]                          rdata;
		logic [1:0]                           rresp;
	} jcid_state_s;

	jcid_state_s s_reg;
	jcid_state_s s_next;

	function automatic jcid_pkg::jcid_tap_e tap_step(jcid_pkg::jcid_tap_e st, logic tms);
		unique case (st)
			jcid_pkg::TAP_RESET:      tap_step = tms ? jcid_pkg::TAP_RESET    : jcid_pkg::TAP_IDLE;
			jcid_pkg::TAP_IDLE:       tap_step = tms ? jcid_pkg::TAP_SEL_DR   : jcid_pkg::TAP_IDLE;
			jcid_pkg::TAP_SEL_DR:     tap_step = tms ? jcid_pkg::TAP_SEL_IR   : jcid_pkg::TAP_CAPTURE_DR;
			jcid_pkg::TAP_CAPTURE_DR: tap_step = tms ? jcid_pkg::TAP_EXIT1_DR : jcid_pkg::TAP_SHIFT_DR;
			jcid_pkg::TAP_SHIFT_DR:   tap_step = tms ? jcid_pkg::TAP_EXIT1_DR : jcid_pkg::TAP_SHIFT_DR;
			jcid_pkg::TAP_EXIT1_DR:   tap_step = tms ? jcid_pkg::TAP_UPDATE_DR : jcid_pkg::TAP_PAUSE_DR;
			jcid_pkg::TAP_PAUSE_DR:   tap_step = tms ? jcid_pkg::TAP_EXIT2_DR : jcid_pkg::TAP_PAUSE_DR;
			jcid_pkg::TAP_EXIT2_DR:   tap_step = tms ? jcid_pkg::TAP_UPDATE_DR : jcid_pkg::TAP_SHIFT_DR;
			jcid_pkg::TAP_UPDATE_DR:  tap_step = tms ? jcid_pkg::TAP_SEL_DR   : jcid_pkg::TAP_IDLE;
			jcid_pkg::TAP_SEL_IR:     tap_step = tms ? jcid_pkg::TAP_RESET    : jcid_pkg::TAP_CAPTURE_IR;
			jcid_pkg::TAP_CAPTURE_IR: tap_step = tms ? jcid_pkg::TAP_EXIT1_IR : jcid_pkg::TAP_SHIFT_IR;
			jcid_pkg::TAP_SHIFT_IR:   tap_step = tms ? jcid_pkg::TAP_EXIT1_IR : jcid_pkg::TAP_SHIFT_IR;
			jcid_pkg::TAP_EXIT1_IR:   tap_step = tms ? jcid_pkg::TAP_UPDATE_IR : jcid_pkg::TAP_PAUSE_IR;
			jcid_pkg::TAP_PAUSE_IR:   tap_step = tms ? jcid_pkg::TAP_EXIT2_IR : jcid_pkg::TAP_PAUSE_IR;
			jcid_pkg::TAP_EXIT2_IR:   tap_step = tms ? jcid_pkg::TAP_UPDATE_IR : jcid_pkg::TAP_SHIFT_IR;
			jcid_pkg::TAP_UPDATE_IR:  tap_step = tms ? jcid_pkg::TAP_SEL_DR   : jcid_pkg::TAP_IDLE;
			default:                  tap_step = jcid_pkg::TAP_RESET;
		endcase
	endfunction

	// Instructions that run on entry into Run-Test/Idle
	function automatic logic is_nv_op(jcid_pkg::jcid_op_t op);
		is_nv_op = (op == jcid_pkg::OP_WIPE_ALL) || (op == jcid_pkg::OP_WRITE_COL) ||
			(op == jcid_pkg::OP_WRITE_COL_STEP) || (op == jcid_pkg::OP_READ_COL) ||
			(op == jcid_pkg::OP_READ_COL_STEP) || (op == jcid_pkg::OP_LOCK_READOUT) ||
			(op == jcid_pkg::OP_STORE_USER_SIG) || (op == jcid_pkg::OP_CLR_CFG_VALID) ||
			(op == jcid_pkg::OP_SET_CFG_VALID) || (op == jcid_pkg::OP_DISCHARGE);
	endfunction

	function automatic logic is_bsr_op(jcid_pkg::jcid_op_t op);
		is_bsr_op = (op == jcid_pkg::OP_EXTEST) || (op == jcid_pkg::OP_SAMPLE) ||
			(op == jcid_pkg::OP_INTEST);
	endfunction

	logic                  tck_rise;
	logic                  tck_fall;
	logic                  fire;
	logic                  dr_lsb;
	logic [COL_DATA_W-1:0] col_rd;
	logic                  col_hit;
	logic [31:0]           status_word;
	logic                  rd_hit;
	logic [31:0]           rd_word;

	always_comb begin
		s_next = s_reg;
		// Only the second stage feeds logic; third stage is an edge history
		s_next.tck1 = tap_in.tck;
		s_next.tck2 = s_reg.tck1;
		s_next.tck3 = s_reg.tck2;
		s_next.tms1 = tap_in.tms;
		s_next.tms2 = s_reg.tms1;
		s_next.tdi1 = tap_in.tdi;
		s_next.tdi2 = s_reg.tdi1;
		tck_rise = s_reg.link_en & s_reg.tck2 & ~s_reg.tck3;
		tck_fall = s_reg.link_en & ~s_reg.tck2 & s_reg.tck3;

		col_rd  = '0;
		col_hit = 1'b0;
		for (int i = 0; i < NUM_COLS; i++) begin
			if (s_reg.col_addr == COL_ADDR_W'(i)) begin
				col_rd  = s_reg.nv[i];
				col_hit = 1'b1;
			end
		end

		unique case (s_reg.ir)
			jcid_pkg::OP_EXTEST, jcid_pkg::OP_SAMPLE, jcid_pkg::OP_INTEST: dr_lsb = s_reg.bsr_sh[0];
			jcid_pkg::OP_IDCODE:        dr_lsb = s_reg.id_sh[0];
			jcid_pkg::OP_SET_COL_ADDR:  dr_lsb = s_reg.col_addr[0];
			jcid_pkg::OP_SHIFT_COL_DATA: dr_lsb = s_reg.col_data[0];
			jcid_pkg::OP_USERCODE:      dr_lsb = s_reg.sig_sh[0];
			default:                    dr_lsb = s_reg.byp;
		endcase

		fire = 1'b0;
		if (tck_rise) begin
			s_next.tap = tap_step(s_reg.tap, s_reg.tms2);
			unique case (s_reg.tap)
				jcid_pkg::TAP_CAPTURE_IR: s_next.ir_sh = jcid_pkg::OP_IDCODE;
				jcid_pkg::TAP_SHIFT_IR:   s_next.ir_sh = {s_reg.tdi2, s_reg.ir_sh[jcid_pkg::IR_W-1:1]};
				jcid_pkg::TAP_UPDATE_IR: begin
					s_next.ir      = s_reg.ir_sh;
					s_next.pending = is_nv_op(s_reg.ir_sh);
					if (s_reg.ir_sh == jcid_pkg::OP_PROG_ENABLE)
						s_next.prog_mode = 1'b1;
					if (s_reg.ir_sh == jcid_pkg::OP_PROG_DISABLE)
						s_next.prog_mode = 1'b0;
				end
				jcid_pkg::TAP_CAPTURE_DR: begin
					s_next.byp   = 1'b0;
					s_next.id_sh = ID_CODE;
					if (is_bsr_op(s_reg.ir))
						s_next.bsr_sh = pin_state;
					if (s_reg.ir == jcid_pkg::OP_USERCODE)
						s_next.sig_sh = s_reg.sig_nv;
				end
				jcid_pkg::TAP_SHIFT_DR: begin
					unique case (s_reg.ir)
						jcid_pkg::OP_EXTEST, jcid_pkg::OP_SAMPLE, jcid_pkg::OP_INTEST:
							s_next.bsr_sh = {s_reg.tdi2, s_reg.bsr_sh[BSR_W-1:1]};
						jcid_pkg::OP_IDCODE:
							s_next.id_sh = {s_reg.tdi2, s_reg.id_sh[31:1]};
						jcid_pkg::OP_SET_COL_ADDR:
							s_next.col_addr = {s_reg.tdi2, s_reg.col_addr[COL_ADDR_W-1:1]};
						jcid_pkg::OP_SHIFT_COL_DATA:
							s_next.col_data = {s_reg.tdi2, s_reg.col_data[COL_DATA_W-1:1]};
						jcid_pkg::OP_USERCODE:
							s_next.sig_sh = {s_reg.tdi2, s_reg.sig_sh[31:1]};
						default:
							s_next.byp = s_reg.tdi2;
					endcase
				end
				jcid_pkg::TAP_UPDATE_DR: begin
					if (is_bsr_op(s_reg.ir))
						s_next.bsr_upd = s_reg.bsr_sh;
				end
				default: begin
				end
			endcase

			// Armed operation runs on the edge that enters Run-Test/Idle
			if (s_next.pending && s_next.tap == jcid_pkg::TAP_IDLE && s_reg.tap != jcid_pkg::TAP_IDLE) begin
				fire           = 1'b1;
				s_next.pending = 1'b0;
			end

			if (s_next.tap == jcid_pkg::TAP_RESET) begin
				s_next.ir        = jcid_pkg::OP_IDCODE;
				s_next.pending   = 1'b0;
				s_next.prog_mode = 1'b0;
				fire             = 1'b0;
			end
		end

		if (fire) begin
			if (s_next.ir == jcid_pkg::OP_DISCHARGE)
				s_next.vpp = 1'b0;
			else if (s_reg.prog_mode) begin
				unique case (s_next.ir)
					jcid_pkg::OP_WIPE_ALL: begin
						s_next.nv        = '0;
						s_next.sig_nv    = '0;
						s_next.lock      = 1'b0;
						s_next.cfg_valid = 1'b0;
						s_next.vpp       = 1'b1;
					end
					jcid_pkg::OP_WRITE_COL, jcid_pkg::OP_WRITE_COL_STEP: begin
						for (int i = 0; i < NUM_COLS; i++) begin
							if (s_next.col_addr == COL_ADDR_W'(i))
								s_next.nv[i] = s_next.col_data;
						end
						s_next.vpp = 1'b1;
						if (s_next.ir == jcid_pkg::OP_WRITE_COL_STEP)
							s_next.col_addr = COL_ADDR_W'(s_next.col_addr + 1'b1);
					end
					jcid_pkg::OP_READ_COL, jcid_pkg::OP_READ_COL_STEP: begin
						// Locked parts return zeros rather than stalling the scan
						s_next.col_data = (s_reg.lock || !col_hit) ? '0 : col_rd;
						if (s_next.ir == jcid_pkg::OP_READ_COL_STEP)
							s_next.col_addr = COL_ADDR_W'(s_next.col_addr + 1'b1);
					end
					jcid_pkg::OP_LOCK_READOUT: begin
						s_next.lock = 1'b1;
						s_next.vpp  = 1'b1;
					end
					jcid_pkg::OP_STORE_USER_SIG: begin
						s_next.sig_nv = s_next.sig_sh;
						s_next.vpp    = 1'b1;
					end
					jcid_pkg::OP_CLR_CFG_VALID: s_next.cfg_valid = 1'b0;
					jcid_pkg::OP_SET_CFG_VALID: s_next.cfg_valid = 1'b1;
					default: begin
					end
				endcase
			end
		end

		// Software-forced TAP reset overrides the pin-driven sequence
		if (s_reg.tap_reset) begin
			s_next.tap       = jcid_pkg::TAP_RESET;
			s_next.ir        = jcid_pkg::OP_IDCODE;
			s_next.pending   = 1'b0;
			s_next.prog_mode = 1'b0;
		end

		s_next.ctl.outputs_highz  = (s_next.ir == jcid_pkg::OP_HIGHZ);
		s_next.ctl.drive_from_bsr = (s_next.ir == jcid_pkg::OP_EXTEST) || (s_next.ir == jcid_pkg::OP_CLAMP) ||
			(s_next.ir == jcid_pkg::OP_IDLE_CLAMP_ALIAS);
		s_next.ctl.intest_mode       = (s_next.ir == jcid_pkg::OP_INTEST);
		s_next.ctl.config_valid      = s_next.cfg_valid;
		s_next.ctl.program_supply_on = s_next.vpp;

		if (tck_fall) begin
			s_next.to.tdo_oe = (s_reg.tap == jcid_pkg::TAP_SHIFT_IR) || (s_reg.tap == jcid_pkg::TAP_SHIFT_DR);
			if (s_reg.tap == jcid_pkg::TAP_SHIFT_IR)
				s_next.to.tdo = s_reg.ir_sh[0];
			else if (s_reg.tap == jcid_pkg::TAP_SHIFT_DR)
				s_next.to.tdo = dr_lsb;
		end

		// AXI4-Lite write: address and data taken in either order
		s_axi_awready = ~s_reg.aw_held & ~s_reg.bvalid;
		s_axi_wready  = ~s_reg.w_held & ~s_reg.bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_held = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;
		if (s_reg.aw_held && s_reg.w_held) begin
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = jcid_pkg::RESP_SLVERR;
			if (s_reg.aw_addr[7:2] == jcid_pkg::REG_CTRL[7:2]) begin
				s_next.bresp = jcid_pkg::RESP_OKAY;
				if (s_reg.w_strb[0]) begin
					s_next.tap_reset = s_reg.w_data[jcid_pkg::CTRL_TAP_RESET_BIT];
					s_next.link_en   = s_reg.w_data[jcid_pkg::CTRL_LINK_EN_BIT];
				end
			end else if (s_reg.aw_addr[7:2] == jcid_pkg::REG_STATUS[7:2] ||
				s_reg.aw_addr[7:2] == jcid_pkg::REG_COL_ADDR[7:2] ||
				s_reg.aw_addr[7:2] == jcid_pkg::REG_USER_SIG[7:2] ||
				s_reg.aw_addr[7:2] == jcid_pkg::REG_IDCODE[7:2])
				s_next.bresp = jcid_pkg::RESP_OKAY;
		end

		// AXI4-Lite read
		status_word = '0;
		status_word[jcid_pkg::ST_PROG_MODE_BIT] = s_reg.prog_mode;
		status_word[jcid_pkg::ST_LOCK_BIT]      = s_reg.lock;
		status_word[jcid_pkg::ST_CFG_VALID_BIT] = s_reg.cfg_valid;
		status_word[jcid_pkg::ST_VPP_BIT]       = s_reg.vpp;
		status_word[jcid_pkg::ST_PENDING_BIT]   = s_reg.pending;
		status_word[jcid_pkg::ST_IR_LSB +: jcid_pkg::IR_W] = s_reg.ir;
		status_word[jcid_pkg::ST_TAP_LSB +: 16] = s_reg.tap;
		rd_hit  = 1'b1;
		rd_word = '0;
		unique case (s_axi_araddr[7:2])
			jcid_pkg::REG_CTRL[7:2]: begin
				rd_word[jcid_pkg::CTRL_TAP_RESET_BIT] = s_reg.tap_reset;
				rd_word[jcid_pkg::CTRL_LINK_EN_BIT]   = s_reg.link_en;
			end
			jcid_pkg::REG_STATUS[7:2]:   rd_word = status_word;
			jcid_pkg::REG_COL_ADDR[7:2]: rd_word[COL_ADDR_W-1:0] = s_reg.col_addr;
			jcid_pkg::REG_USER_SIG[7:2]: rd_word = s_reg.sig_nv;
			jcid_pkg::REG_IDCODE[7:2]:   rd_word = ID_CODE;
			default:                     rd_hit = 1'b0;
		endcase
		s_axi_arready = ~s_reg.rvalid;
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = rd_word;
			s_next.rresp  = rd_hit ? jcid_pkg::RESP_OKAY : jcid_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg           <= '0;
			s_reg.tap       <= jcid_pkg::TAP_RESET;
			s_reg.ir        <= jcid_pkg::OP_IDCODE;
			s_reg.tap_reset <= jcid_pkg::CTRL_TAP_RESET_RST;
			s_reg.link_en   <= jcid_pkg::CTRL_LINK_EN_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tap_out       = s_reg.to;
	assign pin_ctl       = s_reg.ctl;
	assign bsr_drive     = s_reg.bsr_upd;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;

endmodule // jcid_top

// File: tb/jcid_checker.sv
/* Port assertions for jcid_top, bound below.
   Assumes the TAP pins change only at aclk edges. */
`timescale 1ns/10ps
module jcid_checker (
	input wire logic                    aclk,          // Clock
	input wire logic                    aresetn,       // Reset, low
	input wire jcid_pkg::jcid_tap_in_s  tap_in,        // TAP pins
	input wire jcid_pkg::jcid_tap_out_s tap_out,       // TDO
	input wire jcid_pkg::jcid_pin_ctl_s pin_ctl,       // Pin modes
	input wire logic [7:0]              s_axi_araddr,  // Read addr
	input wire logic                    s_axi_arvalid, // Read req
	input wire logic                    s_axi_arready, // Read ack
	input wire logic [31:0]             s_axi_rdata,   // Read data
	input wire logic [1:0]              s_axi_rresp,   // Read resp
	input wire logic                    s_axi_rvalid,  // Read valid
	input wire logic                    s_axi_rready,  // Read ready
	input wire logic [1:0]              s_axi_bresp,   // Write resp
	input wire logic                    s_axi_bvalid,  // Write valid
	input wire logic                    s_axi_bready   // Write ready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	hz_excl_a: assert property (pin_ctl.outputs_highz |-> !pin_ctl.drive_from_bsr && !pin_ctl.intest_mode)
		else $error("highz with other pin mode");
	clamp_excl_a: assert property (pin_ctl.drive_from_bsr |-> !pin_ctl.intest_mode)
		else $error("clamp with intest");
	// TCK half period is wider than the synchroniser, so both samples are settled
	tdo_edge_a: assert property ($changed(tap_out) |-> $past(tap_in.tck, 4) && !$past(tap_in.tck))
		else $error("tdo moved away from a tck fall");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	bad_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h04
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
	cover property (pin_ctl.outputs_highz);
	cover property (pin_ctl.config_valid);
	cover property (tap_out.tdo_oe);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // jcid_checker

bind jcid_top jcid_checker chk_u (.aclk(aclk), .aresetn(aresetn), .tap_in(tap_in), .tap_out(tap_out),
	.pin_ctl(pin_ctl), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// File: tb/jcid_jtag_host.sv
/* Behavioural JTAG controller for jcid_top.
   Assumes a 100 MHz aclk; TCK (80 ns) runs only inside scans and TAP resets. */
`timescale 1ns/10ps
module jcid_jtag_host (
	input  wire logic                    aclk,    // System clock
	output jcid_pkg::jcid_tap_in_s       tap_in,  // Driven pins
	input  wire jcid_pkg::jcid_tap_out_s tap_out  // TDO back
);
	initial tap_in = '0;
	task automatic tick(input logic m, input logic d, output logic q);
		tap_in.tms <= m;
		tap_in.tdi <= d;
		repeat (4) @(posedge aclk);
		q = tap_out.tdo;
		tap_in.tck <= 1'b1;
		repeat (4) @(posedge aclk);
		tap_in.tck <= 1'b0;
	endtask
	task automatic reset_tap();
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
	// Starts and ends in Run-Test/Idle, LSB first
	task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
		tick(1'b1, 1'b0, q);
		tick(1'b0, ~din[n-1], q); // TDI is driven to the complement of the last bit
		repeat (4) @(posedge aclk);
	endtask
endmodule // jcid_jtag_host

// File: tb/jtag_config_instruction_decoder_tb.sv
/* Directed bench for jcid_top over AXI4-Lite and JTAG.
   Assumes jcid_pkg, the checker and the host model compile first. */
`timescale 1ns/10ps
module jtag_config_instruction_decoder_tb;
	localparam logic [31:0] ID = 32'h1357_9BDF; // Arbitrary value
	localparam logic [63:0] COLV = 64'h5A5_C3F0_0F1E;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, mop[6] = '{8'h00, 8'h18, 8'h20, 8'h30, 8'h2C, 8'h16};
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0] bresp, rresp, r;
	logic [2:0] mex[6] = '{3'h2, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
	logic [7:0] bop[6] = '{8'hFF, 8'h85, 8'h0B, 8'h91, 8'h3F, 8'h9D}; // Bypass and unlisted codes only
	logic [15:0] bsr;
	logic [63:0] d;
	jcid_pkg::jcid_tap_in_s tin;
	jcid_pkg::jcid_tap_out_s tout;
	jcid_pkg::jcid_pin_ctl_s pctl;
	int errors = 0, cmp_count = 0;
	always #5 aclk = ~aclk;
	jcid_top #(.ID_CODE(ID)) dut_u (.aclk(aclk), .aresetn(aresetn), .tap_in(tin), .tap_out(tout),
		.pin_state(16'hA5C3), .bsr_drive(bsr), .pin_ctl(pctl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	jcid_jtag_host host_u (.aclk(aclk), .tap_in(tin), .tap_out(tout));
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %0h exp %0h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dd);
		logic pa = 1'b1, pw = 1'b1;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, dd, 3'h7};
		while (pa || pw) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			pa &= !awready;
			pw &= !wready;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		{v, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(v & m, e);
	endtask
	task automatic ir(input logic [7:0] op);
		host_u.scan(1'b1, 8, {56'h0, op}, d);
	endtask
	task automatic dr(input int n, input logic [63:0] x);
		host_u.scan(1'b0, n, x, d);
	endtask
	task automatic close_out();
		if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400_000;
		errors++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h04, 32'hFFFF_FFFF, 32'h0001_1600);
		host_u.reset_tap();
		dr(32, 64'h0);
		chk(d, {32'h0, ID});
		ir(8'h16);
		chk(d, 64'h16);
		chk(tout.tdo_oe, 64'h0);
		foreach (mop[i]) begin
			ir(bop[i]);
			dr(8, 64'hB5);
			chk(d, 64'h6A);
			ir(mop[i]);
			chk(pctl[4:2], mex[i]);
		end
		ir(8'h18);
		host_u.reset_tap();
		rc(8'h04, 32'hFFFF_FF00, 32'h0002_1600);
		ir(8'h1C);
		dr(16, 64'h3C96);
		chk(d, 64'hA5C3);
		chk(bsr, 64'h3C96);
		ir(8'h2F);
		chk(pctl.config_valid, 64'h0);
		ir(8'h15);
		rc(8'h04, 32'h1, 32'h1);
		ir(8'h01);
		dr(10, 64'h3);
		rc(8'h08, 32'h3FF, 32'h3);
		ir(8'h02);
		dr(43, COLV);
		ir(8'h27);
		rc(8'h08, 32'h3FF, 32'h4);
		rc(8'h04, 32'h8, 32'h8);
		chk(pctl.program_supply_on, 64'h1);
		ir(8'h01);
		dr(10, 64'h3);
		ir(8'h02);
		dr(43, 64'h0);
		chk(d, COLV);
		ir(8'h0A);
		ir(8'h02);
		dr(43, 64'h0);
		chk(d, COLV);
		ir(8'h2A);
		rc(8'h08, 32'h3FF, 32'h4);
		ir(8'h02);
		dr(43, 64'h1);
		chk(d, COLV);
		ir(8'h07);
		rc(8'h08, 32'h3FF, 32'h4);
		ir(8'h0A);
		ir(8'h02);
		dr(43, 64'h0);
		chk(d, 64'h1);
		ir(8'h14);
		rc(8'h04, 32'h8, 32'h0);
		chk(pctl.program_supply_on, 64'h0);
		ir(8'h2F);
		chk(pctl.config_valid, 64'h1);
		ir(8'h24);
		chk(pctl.config_valid, 64'h0);
		ir(8'h17);
		dr(32, 64'hC0DE_5EED);
		ir(8'h1A);
		rc(8'h0C, 32'hFFFF_FFFF, 32'hC0DE_5EED);
		ir(8'h09);
		rc(8'h04, 32'h2, 32'h2);
		ir(8'h0A);
		ir(8'h02);
		dr(43, 64'h0);
		chk(d, 64'h0);
		ir(8'h17);
		dr(32, 64'h0);
		chk(d, 64'hC0DE_5EED);
		ir(8'h03);
		rc(8'h04, 32'h2, 32'h0);
		rc(8'h0C, 32'hFFFF_FFFF, 32'h0);
		ir(8'h1E);
		rc(8'h04, 32'h1, 32'h0);
		wr(8'h00, 32'h3);
		rc(8'h04, 32'hFFFF_FF00, 32'h0001_1600);
		wr(8'h00, 32'h2);
		wr(8'h40, 32'h0);
		chk(r, 64'h2);
		rd(8'h40);
		chk(r, 64'h2);
		close_out();
	end
endmodule // jtag_config_instruction_decoder_tb
